/* File: hdl/psf_defines.svh */
/*
  psf_defines.svh: register offsets, field positions and reset values for the
  program status flags block.
  assumes: included by the design module by its bare name.
*/
`ifndef PSF_DEFINES_SVH
`define PSF_DEFINES_SVH

// ---------------------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------------------
`define PSF_STATUS_OFS      8'h00
`define PSF_BANK_OFS        8'h04

// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define PSF_OVF_BIT         2
`define PSF_USER_BIT        1
`define PSF_BANK_LO_BIT     3
`define PSF_BANK_HI_BIT     4

// ---------------------------------------------------------------------------
// reset values and limits
// ---------------------------------------------------------------------------
`define PSF_OVF_RST         1'b0
`define PSF_USER_RST        1'b0
`define PSF_BANK_RST        2'h0
`define PSF_MUL_LIMIT       16'h00ff

`endif

/* File: hdl/psf_pkg.sv */
/*
  psf_pkg.sv: types shared by the program status flags block.
  assumes: compiled before the design module.
*/
package psf_pkg;

  // ---------------------------------------------------------------------------
  // arithmetic operation class from instruction decode
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PSF_OP_NONE,
    PSF_OP_ADD,
    PSF_OP_ADDC,
    PSF_OP_SUBB,
    PSF_OP_MUL,
    PSF_OP_DIV
  } psf_op_type;

  // ---------------------------------------------------------------------------
  // bus data phase state
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PSF_PH_IDLE,
    PSF_PH_READ,
    PSF_PH_WRITE
  } psf_phase_type;

endpackage : psf_pkg

/* File: hdl/psf_flags.sv */
/*
  psf_flags.sv: overflow flag, user flag and register bank select of the
  program status word, with an AHB-Lite slave for software access.
  assumes: one 40 MHz clock, synchronous active-low reset, ALU operands and
  results valid in the cycle that op_valid_i is high.
  read data are captured at the address edge, so a read straight after a
  write already carries the written value.
  an arithmetic update in the same cycle as a software write to the status
  word wins for the overflow flag; hsize_i is not decoded, whole words only.
*/
// Overview of operation
// - ADD, ADDC or SUBB with two's-complement signed overflow sets the overflow flag.
// - MUL whose product exceeds 255 (upper byte nonzero) sets the overflow flag.
// - DIV with a zero divisor sets the overflow flag.
// - any of those five instructions without its overflow condition clears the flag.
// - the user flag is written only by software and no hardware event changes it.
`timescale 1ns/100ps

`include "psf_defines.svh"

module psf_flags
  import psf_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // alu result path
  input  wire logic        op_valid_i,
  input  wire psf_op_type  op_kind_i,
  input  wire logic [7:0]  op_a_i,
  input  wire logic [7:0]  op_b_i,
  input  wire logic [7:0]  op_sum_i,
  input  wire logic [15:0] op_product_i,
  // register operand path
  input  wire logic [2:0]  reg_index_i,
  output logic      [4:0]  reg_addr_o,
  // flag outputs
  output logic             overflow_flag_o,
  output logic             user_flag_one_o,
  output logic             bank_select_high_o,
  output logic             bank_select_low_o
);

  // ---------------------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------------------
  function automatic logic signed_ovf(input logic sa, input logic sb, input logic ss,
                                      input logic sub);
    logic eb;
    eb = sub ? ~sb : sb;
    signed_ovf = (sa == eb) && (ss != sa);
  endfunction : signed_ovf

  function automatic logic overflow_of(input psf_op_type k, input logic [7:0] a,
                                       input logic [7:0] b, input logic [7:0] s,
                                       input logic [15:0] p);
    case (k)
      PSF_OP_ADD, PSF_OP_ADDC: overflow_of = signed_ovf(a[7], b[7], s[7], 1'b0);
      PSF_OP_SUBB:             overflow_of = signed_ovf(a[7], b[7], s[7], 1'b1);
      PSF_OP_MUL:              overflow_of = (p > `PSF_MUL_LIMIT);
      PSF_OP_DIV:              overflow_of = (b == 8'h00);
      default:                 overflow_of = 1'b0;
    endcase
  endfunction : overflow_of

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic          ovf_r;
  logic          ovf_nxt;
  logic          user_r;
  logic          user_nxt;
  logic [1:0]    bank_r;
  logic [1:0]    bank_nxt;
  psf_phase_type phase_r;
  psf_phase_type phase_nxt;
  logic [7:0]    addr_r;
  logic [7:0]    addr_nxt;
  logic [31:0]   rdata_r;
  logic [31:0]   rdata_nxt;
  logic          arith_op;
  logic          take;
  logic          wr_status;
  logic          wr_bank;

  assign arith_op  = op_valid_i && (op_kind_i != PSF_OP_NONE);
  assign take      = hsel_i && hready_i && htrans_i[1];
  assign wr_status = (phase_r == PSF_PH_WRITE) && (addr_r == `PSF_STATUS_OFS);
  assign wr_bank   = (phase_r == PSF_PH_WRITE) && (addr_r == `PSF_BANK_OFS);

  // ---------------------------------------------------------------------------
  // flags
  // ---------------------------------------------------------------------------
  always_comb begin
    ovf_nxt  = ovf_r;
    user_nxt = user_r;
    bank_nxt = bank_r;
    if (wr_status) begin
      ovf_nxt  = hwdata_i[`PSF_OVF_BIT];
      user_nxt = hwdata_i[`PSF_USER_BIT];
      bank_nxt = hwdata_i[`PSF_BANK_HI_BIT:`PSF_BANK_LO_BIT];
    end
    if (wr_bank) begin
      bank_nxt = hwdata_i[1:0];
    end
    if (arith_op) begin
      ovf_nxt = overflow_of(op_kind_i, op_a_i, op_b_i, op_sum_i, op_product_i);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ovf_r  <= `PSF_OVF_RST;
      user_r <= `PSF_USER_RST;
      bank_r <= `PSF_BANK_RST;
    end else begin
      ovf_r  <= ovf_nxt;
      user_r <= user_nxt;
      bank_r <= bank_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------------------
  always_comb begin
    phase_nxt = PSF_PH_IDLE;
    addr_nxt  = addr_r;
    rdata_nxt = rdata_r;
    if (take) begin
      phase_nxt = hwrite_i ? PSF_PH_WRITE : PSF_PH_READ;
      addr_nxt  = haddr_i;
      rdata_nxt = 32'h0000_0000;
      case (haddr_i)
        `PSF_STATUS_OFS: begin
          rdata_nxt[`PSF_BANK_HI_BIT:`PSF_BANK_LO_BIT] = bank_nxt;
          rdata_nxt[`PSF_OVF_BIT]  = ovf_nxt;
          rdata_nxt[`PSF_USER_BIT] = user_nxt;
        end
        `PSF_BANK_OFS: rdata_nxt[1:0] = bank_nxt;
        default:       rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      phase_r <= PSF_PH_IDLE;
      addr_r  <= 8'h00;
      rdata_r <= 32'h0000_0000;
    end else begin
      phase_r <= phase_nxt;
      addr_r  <= addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign hrdata_o    = rdata_r;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign reg_addr_o         = {bank_r, reg_index_i};
  assign overflow_flag_o    = ovf_r;
  assign user_flag_one_o    = user_r;
  assign bank_select_high_o = bank_r[1];
  assign bank_select_low_o  = bank_r[0];

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  property p_add_ovf;
    @(posedge clock_i) disable iff (!reset_n_i)
      (op_valid_i && (op_kind_i == PSF_OP_ADD || op_kind_i == PSF_OP_ADDC))
      |=> (overflow_flag_o == (($past(op_a_i[7]) == $past(op_b_i[7])) &&
                               ($past(op_sum_i[7]) != $past(op_a_i[7]))));
  endproperty
  a_add_ovf: assert property (p_add_ovf) else $error("add overflow wrong");

  property p_subb_ovf;
    @(posedge clock_i) disable iff (!reset_n_i)
      (op_valid_i && op_kind_i == PSF_OP_SUBB)
      |=> (overflow_flag_o == (($past(op_a_i[7]) != $past(op_b_i[7])) &&
                               ($past(op_sum_i[7]) != $past(op_a_i[7]))));
  endproperty
  a_subb_ovf: assert property (p_subb_ovf) else $error("subb overflow wrong");

  property p_mul_ovf;
    @(posedge clock_i) disable iff (!reset_n_i)
      (op_valid_i && op_kind_i == PSF_OP_MUL)
      |=> (overflow_flag_o == ($past(op_product_i[15:8]) != 8'h00));
  endproperty
  a_mul_ovf: assert property (p_mul_ovf) else $error("mul overflow wrong");

  property p_div_zero;
    @(posedge clock_i) disable iff (!reset_n_i)
      (op_valid_i && op_kind_i == PSF_OP_DIV && op_b_i == 8'h00) |=> overflow_flag_o;
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("divide by zero not flagged");

  property p_div_clear;
    @(posedge clock_i) disable iff (!reset_n_i)
      (op_valid_i && op_kind_i == PSF_OP_DIV && op_b_i != 8'h00) |=> !overflow_flag_o;
  endproperty
  a_div_clear: assert property (p_div_clear) else $error("div did not clear flag");

  property p_user_hold;
    @(posedge clock_i) disable iff (!reset_n_i)
      !wr_status |=> $stable(user_flag_one_o);
  endproperty
  a_user_hold: assert property (p_user_hold) else $error("user flag changed by hw");

  property p_bank_addr;
    @(posedge clock_i) disable iff (!reset_n_i)
      wr_bank |=> (reg_addr_o == {$past(hwdata_i[1:0]), reg_index_i});
  endproperty
  a_bank_addr: assert property (p_bank_addr) else $error("register address wrong");

  property p_ovf_hold;
    @(posedge clock_i) disable iff (!reset_n_i)
      (!arith_op && !wr_status) |=> $stable(overflow_flag_o);
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag changed idle");

  // ---------------------------------------------------------------------------
  // software access and reset assertions
  // ---------------------------------------------------------------------------
  property p_ovf_write;
    @(posedge clock_i) disable iff (!reset_n_i)
      (wr_status && !arith_op) |=> (overflow_flag_o == $past(hwdata_i[`PSF_OVF_BIT]));
  endproperty
  a_ovf_write: assert property (p_ovf_write) else $error("overflow flag write lost");

  property p_arith_wins;
    @(posedge clock_i) disable iff (!reset_n_i)
      (wr_status && op_valid_i && op_kind_i == PSF_OP_ADD && op_a_i[7] != op_b_i[7])
      |=> !overflow_flag_o;
  endproperty
  a_arith_wins: assert property (p_arith_wins) else $error("write beat arithmetic");

  property p_user_write;
    @(posedge clock_i) disable iff (!reset_n_i)
      wr_status |=> (user_flag_one_o == $past(hwdata_i[`PSF_USER_BIT]));
  endproperty
  a_user_write: assert property (p_user_write) else $error("user flag write lost");

  property p_bank_write;
    @(posedge clock_i) disable iff (!reset_n_i)
      wr_status
      |=> (reg_addr_o[4:3] == $past(hwdata_i[`PSF_BANK_HI_BIT:`PSF_BANK_LO_BIT]));
  endproperty
  a_bank_write: assert property (p_bank_write) else $error("bank write lost");

  property p_read_status;
    @(posedge clock_i) disable iff (!reset_n_i)
      (take && !hwrite_i && haddr_i == `PSF_STATUS_OFS)
      |=> (hrdata_o == {27'h0, bank_select_high_o, bank_select_low_o, overflow_flag_o,
                        user_flag_one_o, 1'b0});
  endproperty
  a_read_status: assert property (p_read_status) else $error("status read wrong");

  property p_read_bank;
    @(posedge clock_i) disable iff (!reset_n_i)
      (take && !hwrite_i && haddr_i == `PSF_BANK_OFS)
      |=> (hrdata_o == {30'h0, bank_select_high_o, bank_select_low_o});
  endproperty
  a_read_bank: assert property (p_read_bank) else $error("bank read wrong");

  property p_reset_clear;
    @(posedge clock_i)
      !reset_n_i |=> (!overflow_flag_o && !user_flag_one_o && reg_addr_o[4:3] == 2'h0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear");

  // ---------------------------------------------------------------------------
  // covers
  // ---------------------------------------------------------------------------
  c_mul_ovf: cover property (@(posedge clock_i) disable iff (!reset_n_i)
    op_valid_i && op_kind_i == PSF_OP_MUL ##1 overflow_flag_o);
  c_div_zero: cover property (@(posedge clock_i) disable iff (!reset_n_i)
    op_valid_i && op_kind_i == PSF_OP_DIV && op_b_i == 8'h00);
  c_bank3: cover property (@(posedge clock_i) disable iff (!reset_n_i)
    bank_r == 2'h3);
  c_arith_wins: cover property (@(posedge clock_i) disable iff (!reset_n_i)
    arith_op && wr_status);
  c_user_set: cover property (@(posedge clock_i) disable iff (!reset_n_i)
    wr_status && hwdata_i[`PSF_USER_BIT]);

endmodule : psf_flags

/* File: verif/tb_psf_flags.sv */
/*
  tb_psf_flags.sv: self-checking bench for the program status flags block.
  assumes: design files compiled first; zero-wait ahb-lite slave, one clock.
*/
`timescale 1ns/100ps

module tb_psf_flags
  import psf_pkg::*;
;
  logic        clock, reset_n, hsel, hwrite, hreadyout, hresp, op_valid;
  logic        ovf, user, bank_hi, bank_lo;
  logic [1:0]  htrans;
  logic [7:0]  haddr, op_a, op_b, op_sum;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] op_product;
  logic [2:0]  reg_index, hsize;
  logic [4:0]  reg_addr;
  psf_op_type  op_kind;
  int          bad_count, checked;

  psf_flags dut_u (
    .clock_i(clock), .reset_n_i(reset_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .op_valid_i(op_valid), .op_kind_i(op_kind), .op_a_i(op_a), .op_b_i(op_b),
    .op_sum_i(op_sum), .op_product_i(op_product), .reg_index_i(reg_index),
    .reg_addr_o(reg_addr), .overflow_flag_o(ovf), .user_flag_one_o(user),
    .bank_select_high_o(bank_hi), .bank_select_low_o(bank_lo));

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic end_of_test();
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      n = n + 1;
      if (n > 20) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t ns: bus never ready", $time);
        end_of_test();
      end
      @(posedge clock);
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= addr;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wdata;
    wait_ready();
    rd = hrdata;
    #1;
  endtask : bus

  task automatic op(input psf_op_type k, input logic [7:0] a, input logic [7:0] b,
                    input logic [7:0] s, input logic [15:0] p, input logic exp);
    @(posedge clock);
    op_valid   <= 1'b1;
    op_kind    <= k;
    op_a       <= a;
    op_b       <= b;
    op_sum     <= s;
    op_product <= p;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
    check({31'h0, ovf}, {31'h0, exp});
  endtask : op

  // ---------------------------------------------------------------------------
  // clock and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    bad_count = 0;
    checked = 0;
    reset_n = 1'b0;
    {hsel, hwrite, op_valid, htrans, haddr, hwdata} = '0;
    {op_a, op_b, op_sum, op_product} = '0;
    hsize = 3'h2;
    op_kind = PSF_OP_NONE;
    reg_index = 3'h5;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    bus(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0);
    check({27'h0, reg_addr}, 32'h05);
    op(PSF_OP_ADD,  8'h7f, 8'h01, 8'h80, 16'h0, 1'b1);
    op(PSF_OP_ADD,  8'h01, 8'h01, 8'h02, 16'h0, 1'b0);
    op(PSF_OP_ADDC, 8'h80, 8'h80, 8'h00, 16'h0, 1'b1);
    op(PSF_OP_ADDC, 8'h10, 8'h10, 8'h20, 16'h0, 1'b0);
    op(PSF_OP_SUBB, 8'h80, 8'h01, 8'h7f, 16'h0, 1'b1);
    op(PSF_OP_SUBB, 8'h05, 8'h01, 8'h04, 16'h0, 1'b0);
    op(PSF_OP_SUBB, 8'h7f, 8'hff, 8'h80, 16'h0, 1'b1);
    op(PSF_OP_MUL,  8'h10, 8'h10, 8'h00, 16'h0100, 1'b1);
    op(PSF_OP_MUL,  8'h0f, 8'h11, 8'hff, 16'h00ff, 1'b0);
    op(PSF_OP_DIV,  8'h05, 8'h00, 8'h00, 16'h0, 1'b1);
    op(PSF_OP_DIV,  8'h05, 8'h01, 8'h05, 16'h0, 1'b0);
    op(PSF_OP_DIV,  8'h00, 8'h00, 8'h00, 16'h0, 1'b1);
    op(PSF_OP_NONE, 8'h01, 8'h01, 8'h02, 16'h0, 1'b1);
    // user flag survives arithmetic
    bus(1'b1, 8'h00, 32'h2);
    check({31'h0, user}, 32'h1);
    op(PSF_OP_ADD,  8'h7f, 8'h7f, 8'hfe, 16'h0, 1'b1);
    op(PSF_OP_MUL,  8'h01, 8'h01, 8'h01, 16'h0001, 1'b0);
    check({31'h0, user}, 32'h1);
    bus(1'b1, 8'h00, 32'hffffffff);
    bus(1'b0, 8'h00, 32'h0);
    check(rd, 32'h1e);
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b0, 8'h00, 32'h0);
    check(rd, 32'h1e);
    bus(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 8'h00, 32'h0);
    check({31'h0, user}, 32'h0);
    // arithmetic in the write's data phase beats the written overflow bit
    fork
      bus(1'b1, 8'h00, 32'h6);
      begin
        @(posedge clock);
        op(PSF_OP_ADD, 8'h01, 8'hff, 8'h00, 16'h0, 1'b0);
      end
    join
    check({31'h0, user}, 32'h1);
    // reset in mid-run clears flags and bank
    bus(1'b1, 8'h00, 32'h1e);
    check({27'h0, reg_addr[4:3], ovf, user, 1'b0}, 32'h1e);
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    check({27'h0, reg_addr[4:3], ovf, user, 1'b0}, 32'h0);
    bus(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    // every bank encoding through both addresses
    for (int i = 0; i < 4; i++) begin
      reg_index <= 3'(7 - i);
      bus(1'b1, 8'h00, 32'(i) << 3);
      check({27'h0, reg_addr}, {27'h0, i[1:0], 3'(7 - i)});
      check({30'h0, bank_hi, bank_lo}, 32'(i));
      bus(1'b0, 8'h04, 32'h0);
      check(rd, 32'(i));
      bus(1'b1, 8'h04, 32'(3 - i));
      bus(1'b0, 8'h00, 32'h0);
      check(rd, 32'(3 - i) << 3);
      check({27'h0, reg_addr}, {27'h0, 2'(3 - i), 3'(7 - i)});
    end
    check({31'h0, hresp}, 32'h0);
    check({31'h0, hreadyout}, 32'h1);
    end_of_test();
  end
endmodule : tb_psf_flags
